// ### core/serdes_rx_boost_adapt_ctrl.sv
// receive equalizer adaptation controller for one serial lane
// Behaviour
// [R1] auto mode adapts attenuation, boost, feedback equalizer
// [R2] qualify boost on six zeros then 101
// [R3] need many hits on odd and even
// [R4] no pattern: boost kept, no flag raised
// [R5] self test makes prbs-23 and prbs-31
// [R6] boost adapted at five gigabit and above
// [R7] 8b/10b traffic lacks pattern at speed
// [R8] software disables auto, loads fixed values
// [R9] software sweeps values under prbs test
// [R10] software captures adapted values after prbs
// [R11] select drives equalizer: adapted or fixed; feedback equalizer always driven with the adapted value
`timescale 1ns/1ps
`include "rx_adapt_cfg.svh"
module serdes_rx_boost_adapt_ctrl
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // received data, two bits per cycle: [0] even, [1] odd
  input  wire logic [1:0]              rxBits,
  input  wire logic                    rxValid,
  // error hints from the slicer
  input  wire logic                    eyeLow,
  input  wire logic                    eyeHigh,
  // software control
  input  wire logic                    autoAdaptEn,
  input  wire rx_adapt_pkg::lineRate_t lineRate,
  input  wire rx_adapt_pkg::prbsSel_t  prbsSel,
  input  wire logic [`ATTEN_W-1:0]     fixedAttenuation,
  input  wire logic [`BOOST_W-1:0]     fixedBoost,
  // equalizer settings to the analog path
  output logic [`ATTEN_W-1:0]          rx_attenuation_setting,
  output logic [`BOOST_W-1:0]          boostSetting,
  output logic [`FBEQ_W-1:0]           decision_feedback_equalizer,
  // readback of adapted values and self test
  output logic [`ATTEN_W-1:0]          adaptedAttenuation,
  output logic [`BOOST_W-1:0]          adaptedBoost,
  output logic                         prbsOut
);
  import rx_adapt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pattern detector: history of 8 older bits plus the two new ones
  logic [7:0]                hist_q, hist_d;
  logic [9:0]                win;
  logic                      hitEven, hitOdd;

  assign win = {hist_q, rxBits[0], rxBits[1]};

  always_comb
  begin
    hist_d  = rxValid ? win[7:0] : hist_q;
    // oldest bit at msb; pattern 000000101 is nine bits
    hitEven = rxValid && (win[9:1] == {6'h00, `QUAL_TAIL}); // see [R2]
    hitOdd  = rxValid && (win[8:0] == {6'h00, `QUAL_TAIL}); // see [R2]
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      hist_q <= 8'hff;
    else
      hist_q <= hist_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // adaptation state machine and counters
  adaptState_t               st_q, st_d;
  logic [`QUAL_COUNT_W-1:0]  evenCnt_q, evenCnt_d, oddCnt_q, oddCnt_d;
  logic [`QUAL_COUNT_W-1:0]  vote_q, vote_d;
  logic [`ATTEN_W-1:0]       atten_q, atten_d;
  logic [`BOOST_W-1:0]       boost_q, boost_d;
  logic [`FBEQ_W-1:0]        fbeq_q, fbeq_d;
  logic                      boostNeeded;
  logic                      enough;

  // only at five gigabit and up does boost matter enough to adapt
  assign boostNeeded = (lineRate >= lineRate_t'(`RATE_BOOST_MIN)); // see [R6]
  assign enough = (evenCnt_q >= `QUAL_NEEDED) && (oddCnt_q >= `QUAL_NEEDED); // see [R3]

  always_comb
  begin
    st_d      = st_q;
    evenCnt_d = evenCnt_q;
    oddCnt_d  = oddCnt_q;
    vote_d    = vote_q;
    atten_d   = atten_q;
    boost_d   = boost_q;
    fbeq_d    = fbeq_q;
    unique case (st_q)
      ST_IDLE:
      begin
        if (autoAdaptEn)
          st_d = ST_GATHER;
      end
      ST_GATHER:
      begin
        if (hitEven && evenCnt_q != 8'hff)
          evenCnt_d = evenCnt_q + 8'h01;
        if (hitOdd && oddCnt_q != 8'hff)
          oddCnt_d = oddCnt_q + 8'h01;
        // vote: eyeHigh wants more boost, eyeLow wants less
        if (rxValid && eyeHigh && !eyeLow && vote_q != 8'hff)
          vote_d = vote_q + 8'h01;
        else if (rxValid && eyeLow && !eyeHigh && vote_q != 8'h00)
          vote_d = vote_q - 8'h01;
        // attenuation and feedback taps track without qualification
        if (rxValid && eyeHigh && atten_q != '0)
          atten_d = atten_q - 4'h1; // see [R1]
        if (rxValid && eyeLow && fbeq_q != '1)
          fbeq_d = fbeq_q + 5'h01; // see [R1]
        if (!autoAdaptEn)
          st_d = ST_IDLE;
        else if (enough)
          st_d = ST_APPLY;
      end
      ST_APPLY:
      begin
        // boost only moves after qualified training; otherwise held silently
        // vote is centred on 8'h80, so compare against bounds shifted by the threshold
        if (boostNeeded && vote_q >= 8'h80 + `ERR_THRESH && boost_q != '1)
          boost_d = boost_q + 4'h1; // see [R1] see [R4]
        else if (boostNeeded && vote_q < 8'h80 - `ERR_THRESH && boost_q != '0)
          boost_d = boost_q - 4'h1; // see [R1]
        evenCnt_d = '0;
        oddCnt_d  = '0;
        vote_d    = 8'h80;
        st_d      = autoAdaptEn ? ST_GATHER : ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_q      <= ST_IDLE;
      evenCnt_q <= '0;
      oddCnt_q  <= '0;
      vote_q    <= 8'h80;
      atten_q   <= `ATTEN_RESET;
      boost_q   <= `BOOST_RESET;
      fbeq_q    <= `FBEQ_RESET;
    end
    else
    begin
      st_q      <= st_d;
      evenCnt_q <= evenCnt_d;
      oddCnt_q  <= oddCnt_d;
      vote_q    <= vote_d;
      atten_q   <= atten_d;
      boost_q   <= boost_d;
      fbeq_q    <= fbeq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output select: adapted or software fixed attenuation and boost, adapted feedback equalizer
  logic [`ATTEN_W-1:0] attenOut_q, attenOut_d;
  logic [`BOOST_W-1:0] boostOut_q, boostOut_d;
  logic [`FBEQ_W-1:0]  fbeqOut_q, fbeqOut_d;

  // fixed mode lets software hold the equalizer for 8b/10b links
  always_comb
  begin
    attenOut_d = autoAdaptEn ? atten_q : fixedAttenuation; // see [R11] see [R8]
    boostOut_d = autoAdaptEn ? boost_q : fixedBoost; // see [R11] see [R8]
    fbeqOut_d  = fbeq_q;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      attenOut_q <= `ATTEN_RESET;
      boostOut_q <= `BOOST_RESET;
      fbeqOut_q  <= `FBEQ_RESET;
    end
    else
    begin
      attenOut_q <= attenOut_d;
      boostOut_q <= boostOut_d;
      fbeqOut_q  <= fbeqOut_d;
    end
  end

  assign rx_attenuation_setting      = attenOut_q;
  assign boostSetting                = boostOut_q;
  assign decision_feedback_equalizer = fbeqOut_q;
  assign adaptedAttenuation          = atten_q; // see [R10]
  assign adaptedBoost                = boost_q; // see [R10]

  ////////////////////////////////////////////////////////////////////////
  // self test source used for sweeps and capture runs
  prbs_gen u_prbs
  (
    .clock   (clock),
    .reset   (reset),
    .sel     (prbsSel),
    .prbsBit (prbsOut) // see [R5] see [R9]
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence seqQualified;
    st_q == ST_GATHER && enough;
  endsequence

  AST_APPLY_AFTER_QUAL: assert property (@(posedge clock) disable iff (reset) // see [R3]
    (seqQualified and autoAdaptEn) |=> st_q == ST_APPLY)
    else $error("apply not entered after qualification");

  AST_NO_APPLY_EARLY: assert property (@(posedge clock) disable iff (reset) // see [R3]
    st_q == ST_GATHER && !enough |=> st_q != ST_APPLY)
    else $error("apply entered without qualification");

  AST_BOOST_HOLD: assert property (@(posedge clock) disable iff (reset) // see [R4]
    st_q != ST_APPLY |=> boost_q == $past(boost_q))
    else $error("boost changed outside apply");

  AST_FIXED_SEL: assert property (@(posedge clock) disable iff (reset) // see [R11]
    !autoAdaptEn |=> boostSetting == $past(fixedBoost)
      && rx_attenuation_setting == $past(fixedAttenuation))
    else $error("fixed values not driven");

  AST_AUTO_SEL: assert property (@(posedge clock) disable iff (reset) // see [R1]
    autoAdaptEn |=> boostSetting == $past(boost_q))
    else $error("adapted boost not driven");

  AST_LOW_RATE: assert property (@(posedge clock) disable iff (reset) // see [R6]
    !boostNeeded && st_q == ST_APPLY |=> boost_q == $past(boost_q))
    else $error("boost adapted below threshold rate");

  AST_EVEN_HIT: assert property (@(posedge clock) disable iff (reset) // see [R2]
    st_q == ST_GATHER && hitEven && evenCnt_q < 8'h10 |=> evenCnt_q == $past(evenCnt_q) + 8'h01)
    else $error("even hit not counted");

  AST_ODD_HIT: assert property (@(posedge clock) disable iff (reset) // see [R2]
    rxValid && rxBits == 2'b10 && hist_q[6:0] == 7'h01 |-> hitOdd)
    else $error("odd alignment pattern missed");

  AST_PRBS_RUN: assert property (@(posedge clock) disable iff (reset) // see [R5]
    prbsSel != PRBS_OFF ##1 prbsSel != PRBS_OFF [*8] |-> !$stable(u_prbs.lfsr_q))
    else $error("prbs generator stalled");
endmodule // serdes_rx_boost_adapt_ctrl

// ### core/rx_adapt_cfg.svh
// constants for the receive equalizer adaptation controller
`ifndef RX_ADAPT_CFG_SVH
`define RX_ADAPT_CFG_SVH
`define ATTEN_W        4
`define BOOST_W        4
`define FBEQ_W         5
`define ATTEN_RESET    4'h8
`define BOOST_RESET    4'h8
`define FBEQ_RESET     5'h00
`define QUAL_ZEROS     6
`define QUAL_TAIL      3'h5
`define QUAL_COUNT_W   8
`define QUAL_NEEDED    8'h10
`define ERR_THRESH     8'h08
`define RATE_BOOST_MIN 3'h2
`define PRBS23_TAP_A   22
`define PRBS23_TAP_B   17
`define PRBS31_TAP_A   30
`define PRBS31_TAP_B   27
`endif

// ### core/rx_adapt_pkg.sv
// types for the receive equalizer adaptation controller
package rx_adapt_pkg;
  typedef enum logic [2:0] {
    RATE_1G25 = 3'h0,
    RATE_3G125 = 3'h1,
    RATE_5G = 3'h2,
    RATE_6G25 = 3'h3,
    RATE_10G = 3'h4
  } lineRate_t;
  typedef enum logic [1:0] {
    PRBS_OFF = 2'h0,
    PRBS_23 = 2'h1,
    PRBS_31 = 2'h2
  } prbsSel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GATHER = 2'b01,
    ST_APPLY = 2'b11
  } adaptState_t;
endpackage

// ### core/prbs_gen.sv
// prbs-23 / prbs-31 generator for self test
`timescale 1ns/1ps
`include "rx_adapt_cfg.svh"
module prbs_gen
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // control
  input  wire rx_adapt_pkg::prbsSel_t sel,
  // stream
  output logic                    prbsBit
);
  import rx_adapt_pkg::*;
  logic [30:0] lfsr_q;
  logic [30:0] lfsr_d;
  logic        fb;
  logic        bit_q;
  logic        bit_d;

  always_comb
  begin
    fb = 1'b0;
    unique case (sel)
      PRBS_23: fb = lfsr_q[`PRBS23_TAP_A] ^ lfsr_q[`PRBS23_TAP_B];
      PRBS_31: fb = lfsr_q[`PRBS31_TAP_A] ^ lfsr_q[`PRBS31_TAP_B];
      default: fb = 1'b0;
    endcase
    lfsr_d = (sel == PRBS_OFF) ? lfsr_q : {lfsr_q[29:0], fb};
    bit_d  = (sel == PRBS_OFF) ? 1'b0 : fb; // see [R5]
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      lfsr_q <= 31'h7fffffff;
      bit_q  <= 1'b0;
    end
    else
    begin
      lfsr_q <= lfsr_d;
      bit_q  <= bit_d;
    end
  end

  assign prbsBit = bit_q;
endmodule // prbs_gen

// ### sim/remote_serial_tx.sv
// far-end serial transmitter model feeding the receive lane
`timescale 1ns/1ps
module remote_serial_tx
(
  // clock
  input  wire logic       clock,
  // traffic select: 0 silent, 1 qualifying stream, 2 coded idle symbols
  input  wire logic [1:0] mode,
  // lane
  output logic [1:0]      rxBits,
  output logic            rxValid
);
  // six zeros then 101; odd period so hits fall on both alignments
  localparam logic [8:0]  QUAL = 9'b101000000;
  // two comma symbols of opposite disparity; never six zeros then 101
  localparam logic [19:0] CODED = 20'b10100000110101111100;
  int pos_q;

  function automatic logic bitAt(input int k);
    if (mode == 2'h1)
      return QUAL[k % 9];
    return CODED[k % 20];
  endfunction

  initial
  begin
    rxBits  = 2'h0;
    rxValid = 1'b0;
    pos_q   = 0;
  end

  always @(posedge clock)
  begin
    if (mode == 2'h0)
    begin
      // silent line keeps changing so stale data cannot pass as real
      rxValid <= 1'b0;
      rxBits  <= ~rxBits;
    end
    else
    begin
      rxValid <= 1'b1;
      rxBits  <= {bitAt(pos_q + 1), bitAt(pos_q)};
      pos_q   <= (pos_q + 2) % ((mode == 2'h1) ? 9 : 20);
    end
  end
endmodule // remote_serial_tx

// ### sim/test_serdes_rx_boost_adapt_ctrl.sv
// self-checking bench for the receive equalizer adaptation controller
`timescale 1ns/1ps
`include "rx_adapt_cfg.svh"
module test_serdes_rx_boost_adapt_ctrl;
  import rx_adapt_pkg::*;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
  logic clock = 1'b0, reset = 1'b1, eyeLow = 1'b0, eyeHigh = 1'b0, autoAdaptEn = 1'b0;
  logic [1:0]  txMode = 2'h0, rxBits;
  logic        rxValid, prbsOut;
  lineRate_t   lineRate = RATE_5G;
  prbsSel_t    prbsSel = PRBS_OFF;
  logic [3:0]  fixedAtten = 4'h3, fixedBoost = 4'hc, atten, boost, adAtten, adBoost;
  logic [4:0]  fbeq;
  int          failures = 0, checks = 0, cycles = 0;

  remote_serial_tx i_tx (.clock(clock), .mode(txMode), .rxBits(rxBits), .rxValid(rxValid));
  serdes_rx_boost_adapt_ctrl i_dut (.clock(clock), .reset(reset), .rxBits(rxBits),
    .rxValid(rxValid), .eyeLow(eyeLow), .eyeHigh(eyeHigh), .autoAdaptEn(autoAdaptEn),
    .lineRate(lineRate), .prbsSel(prbsSel), .fixedAttenuation(fixedAtten),
    .fixedBoost(fixedBoost), .rx_attenuation_setting(atten), .boostSetting(boost),
    .decision_feedback_equalizer(fbeq), .adaptedAttenuation(adAtten),
    .adaptedBoost(adBoost), .prbsOut(prbsOut));

  always #2.5 clock = ~clock;

  //////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ceiling well above the longest expected run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      close_out();
    end
  end

  task do_reset(input lineRate_t r, input logic auto);
    @(posedge clock);
    reset <= 1'b1;
    lineRate <= r;
    autoAdaptEn <= auto;
    txMode <= 2'h0;
    eyeHigh <= 1'b1;
    eyeLow <= 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
  endtask

  task test_reset;
    do_reset(RATE_5G, 1'b1);
    #1;
    `CHK("atten", `ATTEN_RESET, atten)
    `CHK("boost", `BOOST_RESET, boost)
    `CHK("fbeq", `FBEQ_RESET, fbeq)
    `CHK("prbs", 1'b0, prbsOut)
    $display("done reset");
  endtask

  task test_fixed;
    do_reset(RATE_10G, 1'b0);
    txMode <= 2'h1;
    repeat (300) @(posedge clock);
    #1;
    `CHK("atten", 4'h3, atten)
    `CHK("boost", 4'hc, boost)
    // sweep every fixed pair while a prbs stream runs
    @(posedge clock);
    prbsSel <= PRBS_31;
    for (int a = 0; a < 16; a++)
      for (int b = 0; b < 16; b++)
      begin
        @(posedge clock);
        fixedAtten <= 4'(a);
        fixedBoost <= 4'(b);
        @(posedge clock);
        #1;
        `CHK("sweep atten", 4'(a), atten)
        `CHK("sweep boost", 4'(b), boost)
      end
    @(posedge clock);
    prbsSel <= PRBS_OFF;
    fixedAtten <= 4'h3;
    fixedBoost <= 4'hc;
    $display("done fixed");
  endtask

  task test_adapt;
    do_reset(RATE_5G, 1'b1);
    txMode <= 2'h1;
    for (int i = 0; i < 600 && boost === 4'h8; i++)
    begin
      @(posedge clock);
      #1;
    end
    `CHK("boost", 4'h9, boost)
    `CHK("readback", 4'h9, adBoost)
    `CHK("readback atten", 4'h0, adAtten)
    `CHK("atten", 4'h0, atten)
    @(posedge clock);
    autoAdaptEn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("fixed", 4'hc, boost)
    `CHK("fixed atten", 4'h3, atten)
    $display("done adapt");
  endtask

  task test_coded;
    do_reset(RATE_10G, 1'b1);
    txMode <= 2'h2;
    repeat (200) @(posedge clock);
    eyeHigh <= 1'b0;
    eyeLow <= 1'b1;
    repeat (200) @(posedge clock);
    #1;
    `CHK("boost", 4'h8, boost)
    `CHK("atten", 4'h0, atten)
    `CHK("fbeq", 5'h1f, fbeq)
    $display("done coded");
  endtask

  task test_slow;
    do_reset(RATE_3G125, 1'b1);
    txMode <= 2'h1;
    repeat (400) @(posedge clock);
    #1;
    `CHK("boost", 4'h8, boost)
    $display("done slow");
  endtask

  task test_prbs;
    int ones;
    for (int s = 1; s < 3; s++)
    begin
      ones = 0;
      @(posedge clock);
      prbsSel <= prbsSel_t'(s);
      repeat (64)
      begin
        @(posedge clock);
        #1;
        ones += (prbsOut === 1'b1);
      end
      `CHK("mixed", 1'b1, ones > 8 && ones < 56)
    end
    @(posedge clock);
    prbsSel <= PRBS_OFF;
    repeat (3) @(posedge clock);
    #1;
    `CHK("off", 1'b0, prbsOut)
    $display("done prbs");
  endtask

  initial
  begin
    test_reset();
    test_fixed();
    test_adapt();
    test_coded();
    test_slow();
    test_prbs();
    close_out();
  end
endmodule // test_serdes_rx_boost_adapt_ctrl
